// ==== rtl/prc_config_regs.sv ====
// Function
// - variable latency codes 2,3,4 decoded
// - refresh collision doubles variable latency
// - first data one cycle after count
// - fixed latency codes 2..6 and 8
// - bus config bit 15 selects synchronous
// - refresh config resets to 0010h
// - refresh config selected by pin or code
// - refresh config reads back as written
// - low three bits choose refreshed fraction
// - partial refresh section bounds per code
// - deep sleep stops all refresh
// - bit 4 low plus ce high sleeps
// - ce low 10us wakes, sets bit 4
// - 150us initialisation after wake
// - registers kept through deep sleep
// - identification register read only, selectable
// - identification fields row, version, density
// - fixed latency ignores refresh collisions
//
// configuration, identification and latency logic of the memory device
// assumes acc_* and burst_* come from same-clock bus logic; the two enables are pins
`timescale 1ns/1ps
module prc_config_regs
    import prc_pkg::*;
#(
    parameter int INIT_CYC = PRC_INIT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // device pins
    input wire logic config_register_enable_i,
    input wire logic chip_enable_n_i,
    // register access from the bus interface
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic acc_sw_i,
    input wire logic [1:0] acc_sel_i,
    input wire logic [15:0] acc_code_i,
    input wire logic [15:0] acc_wdata_i,
    output logic [15:0] acc_rdata_o,
    output logic acc_rvalid_o,
    // burst latency
    input wire logic burst_start_i,
    input wire logic refresh_collision_i,
    output logic first_data_o,
    output logic latency_reserved_o,
    // mode and refresh status
    output logic sync_mode_o,
    output logic fixed_latency_o,
    output logic deep_sleep_mode_o,
    output logic init_busy_o,
    output logic refresh_enable_o,
    output logic [22:0] refresh_lo_o,
    output logic [22:0] refresh_hi_o
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [15:0] bus_configuration;
        logic [15:0] refresh_configuration;
        logic deep_sleep_mode;
        logic [PRC_CE_CNT_W-1:0] ce_cnt;
        logic [PRC_INIT_CNT_W-1:0] init_cnt;
        logic busy;
        prc_lat_state_t lat_st;
        logic [3:0] lat_cnt;
        logic first_data;
        logic lat_bad;
        logic [15:0] rdata;
        logic rvalid;
        logic [22:0] ref_lo;
        logic [22:0] ref_hi;
        logic ref_en;
    } prc_state_t;

    localparam logic [15:0] ID_VALUE = {PRC_ID_ROW_256, PRC_ID_VERSION, PRC_ID_DENSITY_128M,
                                        PRC_ID_GENERATION, PRC_ID_VENDOR};
    localparam logic [PRC_CE_CNT_W-1:0] CE_EXIT_LAST = PRC_CE_CNT_W'(PRC_CE_EXIT_CYC - 1);

    prc_state_t s_q;
    prc_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic cfg_en_s;
    logic ce_n_s;

    prc_sync #(.W(1), .RESET_VAL(1'b0)) u_sync_cfg_en (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .async_i(config_register_enable_i),
        .sync_o(cfg_en_s)
    );

    // ce idles high (deselected) through reset
    prc_sync #(.W(1), .RESET_VAL(1'b1)) u_sync_ce (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .async_i(chip_enable_n_i),
        .sync_o(ce_n_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // register selection
    logic sel_bus;
    logic sel_ref;
    logic sel_id;
    logic acc_ok;

    always_comb begin
        // writes are ignored and reads answer 0000h while asleep; ce is high then anyway
        acc_ok = acc_valid_i && !s_q.deep_sleep_mode;
        if (acc_sw_i) begin
            sel_ref = acc_ok && (acc_code_i == PRC_SW_REFRESH);
            sel_id = acc_ok && (acc_code_i == PRC_SW_IDENT);
            sel_bus = acc_ok && (acc_code_i == PRC_SW_BUS);
        end else begin
            sel_ref = acc_ok && cfg_en_s && (acc_sel_i == PRC_SEL_REFRESH);
            sel_id = acc_ok && cfg_en_s && (acc_sel_i == PRC_SEL_IDENT);
            sel_bus = acc_ok && cfg_en_s && (acc_sel_i == PRC_SEL_BUS);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latency decode
    logic [2:0] lat_code;
    logic fixed_mode;
    logic [3:0] lat_n;
    logic lat_rsv;
    logic start_ok;

    always_comb begin
        lat_code = s_q.bus_configuration[PRC_BUS_LAT_LSB +: 3];
        fixed_mode = s_q.bus_configuration[PRC_BUS_FIXED_BIT];
        lat_rsv = 1'b0;
        lat_n = 4'h3;
        if (fixed_mode) begin
            case (lat_code)
                PRC_LAT_C2: lat_n = 4'h2;
                PRC_LAT_C3: lat_n = 4'h3;
                PRC_LAT_C4: lat_n = 4'h4;
                PRC_LAT_C5: lat_n = 4'h5;
                PRC_LAT_C6: lat_n = 4'h6;
                PRC_LAT_C8: lat_n = 4'h8;
                default: lat_rsv = 1'b1;
            endcase
        end else begin
            case (lat_code)
                PRC_LAT_C2: lat_n = 4'h2;
                PRC_LAT_C3: lat_n = 4'h3;
                PRC_LAT_C4: lat_n = 4'h4;
                default: lat_rsv = 1'b1;
            endcase
        end
        // bursts only in synchronous mode and never during initialisation
        start_ok = burst_start_i && s_q.bus_configuration[PRC_BUS_SYNC_BIT]
                   && !s_q.deep_sleep_mode
                   && (s_q.init_cnt == '0) && (s_q.lat_st == PRC_LAT_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    logic [2:0] part_sel;

    always_comb begin
        s_d = s_q;
        part_sel = 3'h0;
        s_d.rvalid = 1'b0;
        s_d.first_data = 1'b0;
        if (clk_en_i) begin
            // register writes; identification ignores writes
            if (sel_bus && acc_write_i) begin
                s_d.bus_configuration = acc_wdata_i;
            end
            if (sel_ref && acc_write_i) begin
                s_d.refresh_configuration = acc_wdata_i;
            end
            if (acc_valid_i && !acc_write_i) begin
                s_d.rvalid = 1'b1;
                s_d.rdata = sel_bus ? s_q.bus_configuration
                          : sel_ref ? s_q.refresh_configuration
                          : sel_id ? ID_VALUE : 16'h0000;
            end

            // decrement first so a wake restarts the full initialisation
            if (s_q.init_cnt != '0) begin
                s_d.init_cnt = s_q.init_cnt - 1'b1;
            end
            // deep sleep entry and exit; registers untouched here but bit 4
            if (!s_q.deep_sleep_mode) begin
                s_d.ce_cnt = '0;
                if (!s_q.refresh_configuration[PRC_REF_SLEEP_BIT] && ce_n_s) begin
                    s_d.deep_sleep_mode = 1'b1;
                end
            end else if (ce_n_s) begin
                s_d.ce_cnt = '0;
            end else if (s_q.ce_cnt == CE_EXIT_LAST) begin
                s_d.deep_sleep_mode = 1'b0;
                s_d.refresh_configuration[PRC_REF_SLEEP_BIT] = 1'b1;
                s_d.init_cnt = PRC_INIT_CNT_W'(INIT_CYC);
                s_d.ce_cnt = '0;
            end else begin
                s_d.ce_cnt = s_q.ce_cnt + 1'b1;
            end
            s_d.busy = (s_d.init_cnt != '0);

            // latency counter
            case (s_q.lat_st)
                PRC_LAT_IDLE: begin
                    if (start_ok) begin
                        s_d.lat_st = PRC_LAT_COUNT;
                        s_d.lat_bad = lat_rsv;
                        // fixed mode already covers worst-case collisions
                        if (!fixed_mode && refresh_collision_i) begin
                            s_d.lat_cnt = {lat_n[2:0], 1'b0};
                        end else begin
                            s_d.lat_cnt = lat_n;
                        end
                    end
                end
                PRC_LAT_COUNT: begin
                    if (s_q.lat_cnt == 4'h0) begin
                        s_d.lat_st = PRC_LAT_DATA;
                        s_d.first_data = 1'b1;
                    end else begin
                        s_d.lat_cnt = s_q.lat_cnt - 1'b1;
                    end
                end
                PRC_LAT_DATA: begin
                    s_d.lat_st = PRC_LAT_IDLE;
                end
                default: begin
                    s_d.lat_st = PRC_LAT_IDLE;
                end
            endcase

            // refresh section follows the next register value so outputs stay in step
            part_sel = s_d.refresh_configuration[PRC_REF_PSEL_LSB +: 3];
            s_d.ref_en = !s_d.deep_sleep_mode && (part_sel != 3'h4);
            s_d.ref_lo = 23'h000000;
            s_d.ref_hi = PRC_ADDR_TOP;
            case (part_sel)
                3'h0: s_d.ref_hi = PRC_ADDR_TOP;
                3'h1: s_d.ref_hi = PRC_ADDR_HALF_END;
                3'h2: s_d.ref_hi = PRC_ADDR_QTR_END;
                3'h3: s_d.ref_hi = PRC_ADDR_EIGHTH_END;
                3'h4: s_d.ref_hi = 23'h000000;
                3'h5: s_d.ref_lo = PRC_ADDR_HALF_BASE;
                3'h6: s_d.ref_lo = PRC_ADDR_QTR_BASE;
                3'h7: s_d.ref_lo = PRC_ADDR_EIGHTH_BASE;
                default: s_d.ref_hi = PRC_ADDR_TOP;
            endcase
        end else begin
            s_d.rvalid = s_q.rvalid;
            s_d.first_data = s_q.first_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q.bus_configuration <= PRC_BUS_RESET;
            s_q.refresh_configuration <= PRC_REF_RESET;
            s_q.deep_sleep_mode <= 1'b0;
            s_q.ce_cnt <= '0;
            s_q.init_cnt <= '0;
            s_q.busy <= 1'b0;
            s_q.lat_st <= PRC_LAT_IDLE;
            s_q.lat_cnt <= 4'h0;
            s_q.first_data <= 1'b0;
            s_q.lat_bad <= 1'b0;
            s_q.rdata <= 16'h0000;
            s_q.rvalid <= 1'b0;
            s_q.ref_lo <= 23'h000000;
            s_q.ref_hi <= PRC_ADDR_TOP;
            s_q.ref_en <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign acc_rdata_o = s_q.rdata;
    assign acc_rvalid_o = s_q.rvalid;
    assign first_data_o = s_q.first_data;
    assign latency_reserved_o = s_q.lat_bad;
    assign sync_mode_o = s_q.bus_configuration[PRC_BUS_SYNC_BIT];
    assign fixed_latency_o = s_q.bus_configuration[PRC_BUS_FIXED_BIT];
    assign deep_sleep_mode_o = s_q.deep_sleep_mode;
    assign init_busy_o = s_q.busy;
    assign refresh_enable_o = s_q.ref_en;
    assign refresh_lo_o = s_q.ref_lo;
    assign refresh_hi_o = s_q.ref_hi;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i || !clk_en_i);

    logic start_acc;
    assign start_acc = start_ok && clk_en_i;

    a_var_lat_two: assert property (
        start_acc && !fixed_mode && lat_code == PRC_LAT_C2 && !refresh_collision_i
        |=> !first_data_o [*3] ##1 first_data_o)
        else $error("variable latency 2 first data late or early");

    a_collision_double: assert property (
        start_acc && !fixed_mode && lat_code == PRC_LAT_C4 && refresh_collision_i
        |-> ##10 first_data_o)
        else $error("collision latency not doubled");

    a_fixed_lat_eight: assert property (
        start_acc && fixed_mode && lat_code == PRC_LAT_C8
        |=> ##1 !first_data_o [*8] ##1 first_data_o)
        else $error("fixed latency 8 not kept");

    a_async_no_burst: assert property (
        burst_start_i && !sync_mode_o && s_q.lat_st == PRC_LAT_IDLE
        |=> s_q.lat_st == PRC_LAT_IDLE)
        else $error("burst started in asynchronous mode");

    a_refresh_readback: assert property (
        (sel_ref && acc_write_i) ##1 (!acc_valid_i [*2])
        ##1 (acc_valid_i && !acc_write_i && sel_ref)
        |=> acc_rdata_o == $past(acc_wdata_i, 4))
        else $error("refresh config readback mismatch");

    a_ident_value: assert property (
        acc_valid_i && !acc_write_i && sel_id |=> acc_rvalid_o && acc_rdata_o == ID_VALUE)
        else $error("identification value wrong");

    a_sleep_entry: assert property (
        !s_q.deep_sleep_mode && !s_q.refresh_configuration[PRC_REF_SLEEP_BIT] && ce_n_s
        |=> deep_sleep_mode_o)
        else $error("deep sleep not entered");

    a_sleep_no_refresh: assert property (
        deep_sleep_mode_o |-> !refresh_enable_o)
        else $error("refresh active in deep sleep");

    a_sleep_exit_init: assert property (
        $fell(deep_sleep_mode_o) |-> s_q.refresh_configuration[PRC_REF_SLEEP_BIT] && init_busy_o)
        else $error("wake without bit 4 set or init");

    a_sleep_keeps_bus: assert property (
        deep_sleep_mode_o |=> $stable(s_q.bus_configuration))
        else $error("bus config changed in deep sleep");

    c_collision_burst: cover property (start_acc && refresh_collision_i ##[1:20] first_data_o);
    c_sleep_exit: cover property ($fell(deep_sleep_mode_o));
    c_ident_read: cover property (acc_valid_i && sel_id && !acc_write_i);

endmodule // prc_config_regs

// ==== rtl/prc_pkg.sv ====
// constants and types for the pseudo-static ram configuration block
// assumes a single 100 MHz clock; all times are converted to cycles here
package prc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int PRC_CLK_PERIOD_NS = 10;
    localparam int PRC_T_CE_EXIT_NS = 10000;
    localparam int PRC_T_INIT_NS = 150000;
    // least times, rounded up to whole cycles
    localparam int PRC_CE_EXIT_CYC = (PRC_T_CE_EXIT_NS + PRC_CLK_PERIOD_NS - 1) / PRC_CLK_PERIOD_NS;
    localparam int PRC_INIT_CYC = (PRC_T_INIT_NS + PRC_CLK_PERIOD_NS - 1) / PRC_CLK_PERIOD_NS;
    localparam int PRC_CE_CNT_W = 10;
    localparam int PRC_INIT_CNT_W = 16;

    ////////////////////////////////////////////////////////////////////////
    // register selection: config_register_enable path (address bits 19:18)
    localparam logic [1:0] PRC_SEL_REFRESH = 2'h0;
    localparam logic [1:0] PRC_SEL_IDENT = 2'h1;
    localparam logic [1:0] PRC_SEL_BUS = 2'h2;
    // software sequence path (third-cycle code)
    localparam logic [15:0] PRC_SW_REFRESH = 16'h0000;
    localparam logic [15:0] PRC_SW_IDENT = 16'h0002;
    localparam logic [15:0] PRC_SW_BUS = 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // bus_configuration fields
    localparam int PRC_BUS_SYNC_BIT = 15;
    localparam int PRC_BUS_FIXED_BIT = 14;
    localparam int PRC_BUS_LAT_LSB = 11;
    localparam logic [15:0] PRC_BUS_RESET = 16'h1D10;

    // latency codes
    localparam logic [2:0] PRC_LAT_C2 = 3'h2;
    localparam logic [2:0] PRC_LAT_C3 = 3'h3;
    localparam logic [2:0] PRC_LAT_C4 = 3'h4;
    localparam logic [2:0] PRC_LAT_C5 = 3'h5;
    localparam logic [2:0] PRC_LAT_C6 = 3'h6;
    localparam logic [2:0] PRC_LAT_C8 = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // refresh_configuration fields
    localparam int PRC_REF_SLEEP_BIT = 4;
    localparam int PRC_REF_PSEL_LSB = 0;
    localparam logic [15:0] PRC_REF_RESET = 16'h0010;

    // partial refresh section bounds (word addresses)
    localparam logic [22:0] PRC_ADDR_TOP = 23'h7FFFFF;
    localparam logic [22:0] PRC_ADDR_HALF_END = 23'h3FFFFF;
    localparam logic [22:0] PRC_ADDR_QTR_END = 23'h1FFFFF;
    localparam logic [22:0] PRC_ADDR_EIGHTH_END = 23'h0FFFFF;
    localparam logic [22:0] PRC_ADDR_HALF_BASE = 23'h400000;
    localparam logic [22:0] PRC_ADDR_QTR_BASE = 23'h600000;
    localparam logic [22:0] PRC_ADDR_EIGHTH_BASE = 23'h700000;

    ////////////////////////////////////////////////////////////////////////
    // device_identification fields
    localparam logic PRC_ID_ROW_256 = 1'b1;
    localparam logic [2:0] PRC_ID_DENSITY_128M = 3'h3;
    // arbitrary neutral values, not any real part
    localparam logic [3:0] PRC_ID_VERSION = 4'h3;
    localparam logic [2:0] PRC_ID_GENERATION = 3'h5;
    localparam logic [4:0] PRC_ID_VENDOR = 5'h0B;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        PRC_LAT_IDLE = 2'b00,
        PRC_LAT_COUNT = 2'b01,
        PRC_LAT_DATA = 2'b10
    } prc_lat_state_t;

endpackage

// ==== rtl/prc_sync.sv ====
// two-flop synchroniser for pin inputs
// assumes the pin is asynchronous to clk_i; state freezes while clk_en_i is low
`timescale 1ns/1ps
module prc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = clk_en_i ? async_i : meta_q;
        sync_d = clk_en_i ? meta_q : sync_q;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule // prc_sync

// ==== tb/prc_ctrl_model.sv ====
// memory controller model: register accesses, bursts and the two pins
// assumes clk_i is the device clock; every drive changes at its falling edge
`timescale 1ns/1ps
module prc_ctrl_model (
    // clock
    input wire logic clk_i,
    // pins
    output logic cfg_en_o,
    output logic ce_n_o,
    // register access
    output logic valid_o,
    output logic write_o,
    output logic sw_o,
    output logic [1:0] sel_o,
    output logic [15:0] code_o,
    output logic [15:0] wdata_o,
    // burst
    output logic start_o,
    output logic coll_o
);
    initial begin
        cfg_en_o = 1'b0;
        ce_n_o = 1'b0;
        valid_o = 1'b0;
        write_o = 1'b0;
        sw_o = 1'b0;
        sel_o = 2'h0;
        code_o = 16'hFFFF;
        wdata_o = 16'hFFFF;
        start_o = 1'b0;
        coll_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // pin path needs the enable settled through the device synchroniser first
    task automatic access(input logic sw, input logic wr, input logic [1:0] sel,
                          input logic [15:0] code, input logic [15:0] data);
        @(negedge clk_i);
        cfg_en_o = !sw;
        repeat (sw ? 1 : 3) @(negedge clk_i);
        valid_o = 1'b1;
        write_o = wr;
        sw_o = sw;
        sel_o = sel;
        code_o = code;
        wdata_o = data;
        @(negedge clk_i);
        valid_o = 1'b0;
        cfg_en_o = 1'b0;
        // released lines must not keep the last value
        wdata_o = ~data;
        code_o = ~code;
    endtask

    task automatic burst(input logic coll);
        @(negedge clk_i);
        start_o = 1'b1;
        coll_o = coll;
        @(negedge clk_i);
        start_o = 1'b0;
        coll_o = ~coll;
    endtask

    // deep sleep entry and exit are driven through this pin only
    task automatic set_ce_n(input logic v);
        @(negedge clk_i);
        ce_n_o = v;
    endtask
endmodule // prc_ctrl_model

// ==== tb/prc_tb_top.sv ====
// self-checking bench for the configuration block with a controller model
// assumes INIT_CYC is shortened to 20; clk_en_i drops only in the freeze scenario
`timescale 1ns/1ps
module psram_latency_refresh_config_tb_top
    import prc_pkg::*;
;
    localparam int INIT = 20;
    logic clk_i, reset_i, clk_en, cfg_en, ce_n, valid, write, sw, start, coll;
    logic [1:0] sel;
    logic [15:0] code, wdata, acc_rdata_o;
    logic acc_rvalid_o, first_data_o, latency_reserved_o, sync_mode_o, fixed_latency_o;
    logic deep_sleep_mode_o, init_busy_o, refresh_enable_o;
    logic [22:0] refresh_lo_o, refresh_hi_o;
    logic [15:0] rd_q[$];
    int lat_q[$];
    int cyc = 0, mismatches = 0, checks = 0, n;
    logic [22:0] lo_tab[8] = '{0, 0, 0, 0, 0, PRC_ADDR_HALF_BASE, PRC_ADDR_QTR_BASE,
        PRC_ADDR_EIGHTH_BASE};
    logic [22:0] hi_tab[8] = '{PRC_ADDR_TOP, PRC_ADDR_HALF_END, PRC_ADDR_QTR_END,
        PRC_ADDR_EIGHTH_END, 0, PRC_ADDR_TOP, PRC_ADDR_TOP, PRC_ADDR_TOP};

    prc_config_regs #(.INIT_CYC(INIT)) dut (.clk_i(clk_i), .reset_i(reset_i),
        .clk_en_i(clk_en), .config_register_enable_i(cfg_en), .chip_enable_n_i(ce_n),
        .acc_valid_i(valid), .acc_write_i(write), .acc_sw_i(sw), .acc_sel_i(sel),
        .acc_code_i(code), .acc_wdata_i(wdata), .acc_rdata_o(acc_rdata_o),
        .acc_rvalid_o(acc_rvalid_o), .burst_start_i(start), .refresh_collision_i(coll),
        .first_data_o(first_data_o), .latency_reserved_o(latency_reserved_o),
        .sync_mode_o(sync_mode_o), .fixed_latency_o(fixed_latency_o),
        .deep_sleep_mode_o(deep_sleep_mode_o), .init_busy_o(init_busy_o),
        .refresh_enable_o(refresh_enable_o), .refresh_lo_o(refresh_lo_o),
        .refresh_hi_o(refresh_hi_o));
    prc_ctrl_model ctrl (.clk_i(clk_i), .cfg_en_o(cfg_en), .ce_n_o(ce_n), .valid_o(valid),
        .write_o(write), .sw_o(sw), .sel_o(sel), .code_o(code), .wdata_o(wdata),
        .start_o(start), .coll_o(coll));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // monitor: settled outputs are sampled mid-cycle
    always @(negedge clk_i) begin
        if (acc_rvalid_o === 1'b1) begin
            if (rd_q.size() == 0) chk("unexpected read answer", 0, 1);
            else chk("read data", rd_q.pop_front(), acc_rdata_o);
        end
        if (first_data_o === 1'b1) begin
            if (lat_q.size() == 0) chk("unexpected first data", 0, 1);
            else chk("first data cycle", lat_q.pop_front(), cyc);
        end
    end

    task automatic drain();
        int k;
        k = 0;
        while ((rd_q.size() != 0 || lat_q.size() != 0) && k < 40) begin
            @(negedge clk_i);
            k++;
        end
        if (k >= 40) begin
            chk("answer timeout", 0, 1);
            test_done();
        end
    endtask

    task automatic rd(input logic s, input logic [1:0] a, input logic [15:0] c,
                      input logic [15:0] exp);
        rd_q.push_back(exp);
        ctrl.access(s, 1'b0, a, c, 16'h0000);
        drain();
    endtask

    function automatic int lat_exp(input bit f, input bit [2:0] c, input bit cl);
        int v;
        v = 3;
        if (c == 3'h0 && f) v = 8;
        else if (c >= 3'h2 && c <= (f ? 3'h6 : 3'h4)) v = c;
        return (!f && cl) ? 2 * v : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic s;
        logic [15:0] v;
        void'($urandom(32'h4842));
        reset_i = 1'b1;
        clk_en = 1'b1;
        repeat (20) @(negedge clk_i);
        reset_i = 1'b0;
        rd(1'b0, PRC_SEL_REFRESH, 16'h0, 16'h0010);
        rd(1'b1, 2'h0, PRC_SW_BUS, PRC_BUS_RESET);
        v = {PRC_ID_ROW_256, PRC_ID_VERSION, PRC_ID_DENSITY_128M, PRC_ID_GENERATION,
             PRC_ID_VENDOR};
        ctrl.access(1'b0, 1'b1, PRC_SEL_IDENT, 16'h0, 16'($urandom));
        rd(1'b0, PRC_SEL_IDENT, 16'h0, v);
        rd(1'b1, 2'h0, PRC_SW_IDENT, v);
        rd(1'b0, 2'h3, 16'h0, 16'h0000);
        rd(1'b1, 2'h0, 16'h0003, 16'h0000);
        chk("sync after reset", 0, sync_mode_o);
        // partial refresh codes, path picked at random
        for (int p = 0; p < 8; p++) begin
            s = 1'($urandom_range(0, 1));
            v = {11'h000, 1'b1, 1'b0, 3'(p)};
            ctrl.access(s, 1'b1, PRC_SEL_REFRESH, PRC_SW_REFRESH, v);
            rd(!s, PRC_SEL_REFRESH, PRC_SW_REFRESH, v);
            chk("refresh enable", p != 4, refresh_enable_o);
            chk("refresh low", lo_tab[p], refresh_lo_o);
            chk("refresh high", hi_tab[p], refresh_hi_o);
        end
        // every latency code in both modes, with and without collision
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 8; c++) begin
                for (int cl = 0; cl < 2; cl++) begin
                    v = {1'b1, 1'(f), 3'(c), 11'h510};
                    ctrl.access(1'b1, 1'b1, 2'h0, PRC_SW_BUS, v);
                    chk("fixed mode", f, fixed_latency_o);
                    ctrl.burst(1'(cl));
                    lat_q.push_back(cyc + lat_exp(f, c, cl) + 1);
                    drain();
                    chk("reserved code flag", lat_exp(f, c, 0) == 3 && c != 3,
                        latency_reserved_o);
                end
            end
        end
        // clock enable low holds the count; this code fits the 100 MHz clock
        ctrl.access(1'b1, 1'b1, 2'h0, PRC_SW_BUS, {1'b1, 1'b1, PRC_LAT_C6, 11'h510});
        ctrl.burst(1'b0);
        lat_q.push_back(cyc + 12);
        clk_en = 1'b0;
        repeat (5) @(negedge clk_i);
        clk_en = 1'b1;
        drain();
        // asynchronous mode refuses bursts
        ctrl.access(1'b1, 1'b1, 2'h0, PRC_SW_BUS, PRC_BUS_RESET);
        chk("sync mode clear", 0, sync_mode_o);
        ctrl.burst(1'b0);
        repeat (15) @(negedge clk_i);
        // deep sleep entry, write refused, then wake by ce low
        ctrl.access(1'b0, 1'b1, PRC_SEL_REFRESH, 16'h0, 16'h0005);
        ctrl.set_ce_n(1'b1);
        repeat (6) @(negedge clk_i);
        chk("sleep entered", 1, deep_sleep_mode_o);
        chk("refresh stopped", 0, refresh_enable_o);
        ctrl.access(1'b1, 1'b1, 2'h0, PRC_SW_REFRESH, 16'h0013);
        ctrl.set_ce_n(1'b0);
        n = 0;
        while (deep_sleep_mode_o !== 1'b0 && n < 1100) begin
            @(negedge clk_i);
            n++;
        end
        chk("wake cycles", 1, n >= 999 && n <= 1006);
        chk("init running", 1, init_busy_o);
        n = 0;
        while (init_busy_o !== 1'b0 && n < 3 * INIT) begin
            @(negedge clk_i);
            n++;
        end
        chk("init cycles", 1, n >= INIT - 2 && n <= INIT + 2);
        rd(1'b0, PRC_SEL_REFRESH, 16'h0, 16'h0015);
        rd(1'b0, PRC_SEL_BUS, 16'h0, PRC_BUS_RESET);
        chk("refresh back", 1, refresh_enable_o);
        test_done();
    end
endmodule // psram_latency_refresh_config_tb_top
